// ---- rtl/fcpwm_regs.svh ----
// Purpose: Register offsets, reset values and field positions of the PWM.
// Assumes: Byte addresses on an 8-bit register port.
// Notes:   Offsets of the control and counter registers are local picks.
`ifndef FCPWM_REGS_SVH
`define FCPWM_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define FCPWM_DUTY0_ADDR     8'h36
`define FCPWM_DUTY1_ADDR     8'h37
`define FCPWM_DUTY2_ADDR     8'h38
`define FCPWM_DUTY3_ADDR     8'h39
`define FCPWM_CTRL_ADDR      8'h35
`define FCPWM_CNT_ADDR       8'h34
`define FCPWM_CLKSEL_ADDR    8'h33

// ----------------------------------------------------------------------
// Values and fields
// ----------------------------------------------------------------------
`define FCPWM_DUTY_RST       8'h00
`define FCPWM_CNT_PRESET     8'hff
`define FCPWM_CNT_RELOAD     8'h01
`define FCPWM_CNT_MAX        8'hff
`define FCPWM_DUTY_ZERO      8'h00
`define FCPWM_CLKSEL_LSB     0
`define FCPWM_DIV8_LAST      3'h7

`endif

// ---- rtl/fcpwm_pkg.sv ----
// Purpose: Types shared by the PWM design.
// Assumes: Four channels of eight bits.
// Notes:   Constants live in the register header.
package fcpwm_pkg;

  typedef enum logic [1:0] {
    fcpwm_clk_bus   = 2'b00,
    fcpwm_clk_div2  = 2'b01,
    fcpwm_clk_div8  = 2'b10,
    fcpwm_clk_timer = 2'b11
  } fcpwm_clksel_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fcpwm_bus_type;

endpackage

// ---- rtl/fcpwm_top.sv ----
// Operation
// (R1) Two-bit select picks bus, /2, /8, timer pulse.
// (R2) Software idles channels before changing select.
// (R3) Prescaler runs only while a channel enabled.
// (R4) Counter steps per tick, overflow loads 01.
// (R5) Write or all disabled presets counter FF.
// (R6) Counter read has no side effect.
// (R7) Enabled duty writes wait for rollover.
// (R8) Overflow: reload, set outputs, copy duty.
// (R9) Count equal compare clears channel output.
// (R10) Compare zero keeps output low always; a zero copied in at overflow still gives one high cycle.
// (R11) Duty FF keeps output high all period.
// (R12) Duty then counter write applies duty now.
// (R13) Enabled channel drives pin over direction.
// (R14) Reset clears all channel enables.
// (R15) Reset clears all duty registers.
// (R16) Duty read returns last written value.
// (R17) Duty registers sit at 36 to 39.
// (R18) Period spans 255 counter ticks.
// (R19) Wait mode changes nothing.
// (R20) Stop freezes state, resumes unchanged.
// (R21) Late enabled channel shares running counter.
//
// Purpose: Four-channel 8-bit PWM with shared counter and port G muxing.
// Assumes: Timer compare pulse is a one-cycle pulse on mclk_i.
// Notes:   Stop mode is modelled by a clock-run input gating all state but the read data register.
`timescale 1ns/1ns
`include "fcpwm_regs.svh"

module fcpwm_top
  import fcpwm_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       clk_run_i,
  input  wire logic       timer2_compare_pulse_i,
  input  wire logic [3:0] port_g_direction_i,
  input  wire logic [3:0] port_g_data_i,
  output logic      [3:0] pin_out_o,
  output logic      [3:0] pin_oe_o,
  output logic      [3:0] pwm_level_o
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  fcpwm_bus_type    bus;
  fcpwm_clksel_type clk_select;
  logic [3:0]       channel_enable_bit;
  logic [7:0]       shared_period_counter;
  logic [7:0]       duty_latch [4];
  logic [7:0]       duty_buf   [4];
  logic [3:0]       out_ff;
  logic [2:0]       prescale;
  logic             tick;
  logic             any_en;
  logic             counter_overflow;
  logic             cnt_write;
  logic [3:0]       duty_match;
  logic [7:0]       next_rdata;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  function automatic logic is_duty(input logic [7:0] a, input int ch);
    is_duty = (a == `FCPWM_DUTY0_ADDR + 8'(ch)); // R17
  endfunction

  assign any_en    = |channel_enable_bit;
  assign cnt_write = bus.wr && bus.addr == `FCPWM_CNT_ADDR;

  // --------------------------------------------------------------------
  // Control and select registers
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      channel_enable_bit <= 4'h0; // R14
      clk_select         <= fcpwm_clk_bus;
    end
    else if (clk_run_i && bus.wr)
    begin
      if (bus.addr == `FCPWM_CTRL_ADDR)
        channel_enable_bit <= bus.wdata[3:0];
      if (bus.addr == `FCPWM_CLKSEL_ADDR)
        clk_select <= fcpwm_clksel_type'(bus.wdata[1:0]); // R1 R2
    end
  end

  // --------------------------------------------------------------------
  // Prescaler, held cleared while idle so the first tick comes a full /2 or /8 after enable
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      prescale <= 3'h0;
    else if (!any_en)
      prescale <= 3'h0; // R3
    else if (clk_run_i)
      prescale <= prescale + 3'h1; // R20
  end

  always_comb
  begin
    case (clk_select) // R1
      fcpwm_clk_bus:   tick = any_en; // R3
      fcpwm_clk_div2:  tick = any_en && prescale[0];
      fcpwm_clk_div8:  tick = any_en && prescale == `FCPWM_DIV8_LAST;
      fcpwm_clk_timer: tick = timer2_compare_pulse_i;
      default:         tick = 1'b0;
    endcase
  end

  assign counter_overflow = tick && any_en &&
                            shared_period_counter == `FCPWM_CNT_MAX;

  // --------------------------------------------------------------------
  // Shared counter
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      shared_period_counter <= `FCPWM_CNT_PRESET;
    else if (!clk_run_i)
      shared_period_counter <= shared_period_counter; // R20 R19
    else if (cnt_write || !any_en)
      shared_period_counter <= `FCPWM_CNT_PRESET; // R5 R12
    else if (counter_overflow)
      shared_period_counter <= `FCPWM_CNT_RELOAD; // R4 R18 R21
    else if (tick)
      shared_period_counter <= shared_period_counter + 8'h01; // R4
  end

  // --------------------------------------------------------------------
  // Per-channel duty and output flip-flop
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_ch
      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
          duty_latch[g] <= `FCPWM_DUTY_RST; // R15
        else if (clk_run_i && bus.wr && is_duty(bus.addr, g))
          duty_latch[g] <= bus.wdata; // R16
      end

      // A disabled channel follows its latch so enabling starts clean.
      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
          duty_buf[g] <= `FCPWM_DUTY_RST;
        else if (clk_run_i &&
                 (!channel_enable_bit[g] || counter_overflow || cnt_write))
          duty_buf[g] <= duty_latch[g]; // R7 R8 R12
      end

      assign duty_match[g] = shared_period_counter == duty_buf[g];

      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
          out_ff[g] <= 1'b0;
        else if (!clk_run_i)
          out_ff[g] <= out_ff[g]; // R20
        else if (duty_buf[g] == `FCPWM_DUTY_ZERO || !channel_enable_bit[g])
          out_ff[g] <= 1'b0; // R10
        else if (counter_overflow)
          out_ff[g] <= 1'b1; // R8 R11
        else if (tick && duty_match[g] && duty_buf[g] != `FCPWM_CNT_MAX)
          out_ff[g] <= 1'b0; // R9
      end

      always_comb
      begin
        if (channel_enable_bit[g])
        begin
          pin_out_o[g] = out_ff[g]; // R13
          pin_oe_o[g]  = 1'b1;
        end
        else
        begin
          pin_out_o[g] = port_g_data_i[g];
          pin_oe_o[g]  = port_g_direction_i[g];
        end
      end
    end
  endgenerate

  assign pwm_level_o = out_ff;

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    if (bus.addr == `FCPWM_CTRL_ADDR)
      next_rdata = {4'h0, channel_enable_bit};
    else if (bus.addr == `FCPWM_CNT_ADDR)
      next_rdata = shared_period_counter; // R6
    else if (bus.addr == `FCPWM_CLKSEL_ADDR)
      next_rdata = {6'h00, clk_select};
    else
      for (int i = 0; i < 4; i++)
        if (is_duty(bus.addr, i))
          next_rdata = duty_latch[i]; // R16
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (bus.rd)
      rdata_o <= next_rdata;
    else
      rdata_o <= 8'h00;
  end

endmodule

// ---- sim/fcpwm_load.sv ----
// Purpose: Port G load that totals high cycles per pin.
// Assumes: A pull-down holds undriven pins low.
// Notes: A lost pin enable thus shows as low time.
`timescale 1ns/1ns
module fcpwm_load (
  input  wire logic             mclk_i,
  input  wire logic             clr_i,
  input  wire logic [3:0]       pin_out_i,
  input  wire logic [3:0]       pin_oe_i,
  output logic      [3:0][11:0] hi_o
);
  always_ff @(posedge mclk_i)
    for (int i = 0; i < 4; i++)
      hi_o[i] <= clr_i ? 12'h0 : hi_o[i] + 12'(pin_out_i[i] & pin_oe_i[i]);
endmodule

// ---- sim/fcpwm_top_assertions.sv ----
// Purpose: Port checks of the PWM.
// Assumes: Enables mirror the register at 35.
// Notes: A disable may reach pwm_level_o a cycle late.
`timescale 1ns/1ns
module fcpwm_top_assertions (
  input wire logic       mclk_i, rst_i, wr_i, rd_i, clk_run_i,
  input wire logic [7:0] addr_i, wdata_i, rdata_o,
  input wire logic [3:0] port_g_direction_i, port_g_data_i,
  input wire logic [3:0] pin_out_o, pin_oe_o, pwm_level_o
);
  logic [3:0] en;
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i) en <= 4'h0;
    else if (wr_i && clk_run_i && addr_i == 8'h35) en <= wdata_i[3:0];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_pin_enable: assert property (pin_oe_o == (en | port_g_direction_i))
    else $error("pin enable");
  a_pin_value: assert property (pin_out_o ==
    ((en & pwm_level_o) | (~en & port_g_data_i))) else $error("pin value");
  a_off_low: assert property ((pwm_level_o & ~en & ~$past(en)) == 4'h0)
    else $error("disabled output");
  a_preset_read: assert property (rd_i && addr_i == 8'h34 && en == 0 &&
    $past(en) == 0 |=> rdata_o == 8'hff) else $error("preset");
  a_duty_read: assert property (rd_i && addr_i inside {[8'h36:8'h39]} &&
    $past(wr_i, 2) && $past(clk_run_i, 2) && !$past(wr_i) &&
    $past(addr_i, 2) == addr_i |=> rdata_o == $past(wdata_i, 3))
    else $error("duty read");
  a_unmapped_read: assert property (rd_i && addr_i == 8'h3a |=>
    rdata_o == 8'h00) else $error("unmapped read");
  a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("idle read");
  a_stop_freeze: assert property (!clk_run_i |=> $stable(pwm_level_o))
    else $error("stop");
  c_sync: cover property (wr_i && addr_i == 8'h34 && en != 0);
  c_stop: cover property (!clk_run_i && en != 0);
  c_fall: cover property ($fell(pwm_level_o[1]));
endmodule
bind fcpwm_top fcpwm_top_assertions u_chk (.*);

// ---- sim/test_fcpwm_top.sv ----
// Purpose: Self-checking bench for the PWM.
// Assumes: Undriven pins read low.
// Notes: Duty is judged by high cycles over one period.
`timescale 1ns/1ns
module test_fcpwm_top;
  logic mclk = 0, rst = 1, wr = 0, rd = 0, run = 1, tp = 0, clr = 0;
  logic [1:0] t = 0;
  logic [7:0] addr = 0, wd = 0, rdata;
  logic [3:0] pout, poe;
  logic [3:0][11:0] hi;
  logic [7:0] d [4];
  int fails = 0, total_checks = 0, seed = 78697, f;
  fcpwm_top u_dut (.mclk_i(mclk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .clk_run_i(run),
    .timer2_compare_pulse_i(tp), .port_g_direction_i(4'h0),
    .port_g_data_i(4'hf), .pin_out_o(pout), .pin_oe_o(poe),
    .pwm_level_o());
  fcpwm_load u_load (.mclk_i(mclk), .clr_i(clr), .pin_out_i(pout),
    .pin_oe_i(poe), .hi_o(hi));
  initial forever #50 mclk = ~mclk;
  // A timer pulse every fourth cycle makes each tick four cycles long.
  always @(posedge mclk)
  begin
    t <= t + 2'd1;
    tp <= &t;
  end
  function logic [11:0] hi_exp(input logic [7:0] v, input int m);
    return 12'(v * m);
  endfunction
  task chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    {wr, rd, addr, wd} <= {w, !w, a, v};
    @(posedge mclk);
    {wr, rd} <= 2'b00;
    #1 if (!w) chk(12'(rdata), 12'(v));
  endtask
  task meas(input int p);
    @(posedge mclk) clr <= 1;
    @(posedge mclk) clr <= 0;
    repeat (p) @(posedge mclk);
    #1;
  endtask
  task print_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge mclk);
    fails++;
    print_verdict;
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 0;
    bus(0, 8'h34, 8'hff);
    bus(0, 8'h3a, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      bus(0, 8'h36 + 8'(i), 8'h00);
      d[i] = 8'($random(seed));
      bus(1, 8'h36 + 8'(i), d[i]);
      bus(0, 8'h36 + 8'(i), d[i]);
    end
    d[0] = 8'h00;
    d[3] = 8'hff;
    for (int s = 0; s < 4; s++)
    begin
      f = s == 3 ? 4 : 1 << (s + s / 2);
      d[2] = 8'($random(seed));
      bus(1, 8'h35, 8'h00);
      bus(1, 8'h33, 8'(s));
      for (int i = 0; i < 4; i++)
        bus(1, 8'h36 + 8'(i), d[i]);
      bus(1, 8'h35, 8'h0f);
      run <= 0;
      repeat (30) @(posedge mclk);
      run <= 1;
      repeat (510 * f) @(posedge mclk);
      meas(255 * f);
      for (int i = 0; i < 4; i++)
        chk(hi[i], hi_exp(d[i], f));
    end
    bus(1, 8'h34, 8'h00);
    repeat (8) @(posedge mclk);
    // The new duty must wait for rollover, so the pin stays high.
    bus(1, 8'h39, 8'h20);
    meas(200);
    chk(hi[3], 12'd200);
    d[1] = 8'($random(seed));
    bus(1, 8'h37, d[1]);
    bus(1, 8'h34, 8'($random(seed)));
    repeat (4) @(posedge mclk);
    meas(1020);
    chk(hi[1], hi_exp(d[1], 4));
    print_verdict;
  end
endmodule
